/* rtl/apoc_pkg.sv */
/*
  Shared constants, types and decode functions of the converter
  control and parallel output block.
  Assumes a sample clock period given below and 13-bit sample words.
*/
`default_nettype none
package apoc_pkg;

  // Sample word layout
  localparam int DATA_W = 13;
  localparam int WORD_W = 14;
  localparam int FLAG_BIT = 13;
  localparam int MSB_BIT = 12;
  localparam logic [DATA_W-1:0] CODE_ONES = 13'h1FFF;
  localparam logic [DATA_W-1:0] CODE_ZEROS = 13'h0000;

  // Pipeline depth and buffer depth
  localparam int LAT_CYC = 12;
  localparam int BUF_DEPTH = 2;

  // Start-up times, in sample clock cycles
  localparam int SAMPLE_CLK_NS = 10;
  localparam int SYS_CLK_NS = 10;
  localparam int T_PD_CYC = 900;
  localparam int T_SLP_CYC = 20;
  localparam int PD_START_CNT = T_PD_CYC * SAMPLE_CLK_NS / SYS_CLK_NS;
  localparam int SLP_START_CNT = T_SLP_CYC * SAMPLE_CLK_NS / SYS_CLK_NS;
  // Two synchroniser stages, state load and the final zero cycle
  localparam int WAKE_OVERHEAD = 4;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] PD_LOAD =
    CNT_W'(PD_START_CNT - WAKE_OVERHEAD);
  localparam logic [CNT_W-1:0] SLP_LOAD =
    CNT_W'(SLP_START_CNT - WAKE_OVERHEAD);
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

  // Synchronised control pin positions
  localparam int PIN_W = 5;
  localparam int PIN_PDN = 4;
  localparam int PIN_SLPN = 3;
  localparam int PIN_FMT = 2;
  localparam int PIN_BHI = 1;
  localparam int PIN_BLO = 0;
  // Power down seen as active until the pins are sampled
  localparam logic [PIN_W-1:0] PIN_RST = 5'h00;

  // Link side control positions
  localparam int LCTL_W = 3;
  localparam int LCTL_PD = 0;
  localparam int LCTL_FWDN = 1;
  localparam int LCTL_OEN = 2;
  localparam logic [LCTL_W-1:0] LCTL_RST = 3'h7;

  // Common-mode buffer bias codes
  localparam logic [1:0] BIAS_OFF = 2'h0;
  localparam logic [1:0] BIAS_50UA = 2'h1;
  localparam logic [1:0] BIAS_500UA = 2'h2;
  localparam logic [1:0] BIAS_1MA = 2'h3;
  localparam logic [3:0] BIAS_NONE = 4'h0;

  // Power state, Gray coded along off, wake, run, sleep
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_WAKE = 2'h1,
    ST_RUN = 2'h3,
    ST_SLEEP = 2'h2
  } apoc_state_t;

  // One-hot bias enable: bit 0 50uA, bit 1 500uA, bit 2 1mA
  function automatic logic [3:0] apoc_bias_decode(input logic [1:0] sel);
    logic [3:0] res;
    res = BIAS_NONE;
    if (sel != BIAS_OFF) begin
      res[sel - 2'h1] = 1'h1;
    end
    return res;
  endfunction : apoc_bias_decode

  // Offset binary to chosen number format
  function automatic logic [DATA_W-1:0] apoc_format(
    input logic [DATA_W-1:0] code, input logic twos);
    return twos ? {~code[MSB_BIT], code[MSB_BIT-1:0]} : code;
  endfunction : apoc_format

endpackage : apoc_pkg
`default_nettype wire

/* rtl/apoc_buf2.sv */
/*
  Small valid/ready buffer holding whole sample words.
  Assumes one clock and a synchronous active-low reset copy.
*/
`timescale 1ns/1ns
`default_nettype none
module apoc_buf2 #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0] count_q;
  logic [PTR_W:0] count_d;
  logic notFull_q;
  wire push = inValid && notFull_q;
  wire pop = outValid && outReady;

  assign count_d = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  assign inReady = notFull_q;
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'h1;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + 1'h1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + 1'h1;
      end
      count_q <= count_d;
      notFull_q <= (count_d != CNT_FULL);
    end
  end

endmodule : apoc_buf2
`default_nettype wire

/* rtl/apoc_ctrl.sv */
/*
  Control pins, sample pipeline and parallel output port of the
  converter; top module of the block.
  Assumes core samples arrive on sys_clk in offset binary, and the
  link clock is free running and unrelated to sys_clk.
*/
// How it works
// - forwarded clock driven while its enable pin is low, floated when high.
// - number format pin 0 gives offset binary, 1 two's complement.
// - power down pin low puts the whole block in power down.
// - in power down data, range flag, forwarded clock, bias enables and active status go to zero.
// - data outputs floated while output enable pin high, driven when low.
// - range flag high on every sample whose input left the range.
// - a forwarded clock lets the receiver capture the data.
// - bias pins 00 off, 01 50uA, 10 500uA, 11 1mA.
// - after sleep release, running again within 20 cycles.
// - after power down release, running again within 900 cycles.
// - out of range forces code to all ones or all zeros.
`timescale 1ns/1ns
`default_nettype none
module apoc_ctrl import apoc_pkg::*; (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic linkClk,
  // Static control pins
  input wire logic powerDownN,
  input wire logic sleepN,
  input wire logic numberFormatSel,
  input wire logic cmBiasSelHi,
  input wire logic cmBiasSelLo,
  input wire logic fwdClkEnableN,
  input wire logic outEnableN,
  // Converter core samples
  input wire logic [DATA_W-1:0] coreSample,
  input wire logic coreOver,
  input wire logic coreUnder,
  input wire logic coreValid,
  output logic coreReady,
  // Parallel output pins
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic rangeExceededFlag,
  output logic rangeOe,
  output logic fwdDataClk,
  output logic fwdClkOe,
  // Status and bias control
  output logic [3:0] cmBiasEn,
  output logic converterActive
);

  localparam int PD_WAIT = PD_START_CNT;
  localparam int SLP_WAIT = SLP_START_CNT;
  localparam logic [3:0] RUN_MAX = 4'hF;

  // Reset release and pin synchronisers
  logic rstS1_q, rstN_q;
  logic [PIN_W-1:0] pinS1_q, pinS2_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstS1_q <= 1'h0;
      rstN_q <= 1'h0;
    end else begin
      rstS1_q <= 1'h1;
      rstN_q <= rstS1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstN_q) begin
      pinS1_q <= PIN_RST;
      pinS2_q <= PIN_RST;
    end else begin
      pinS1_q <= {powerDownN, sleepN, numberFormatSel, cmBiasSelHi,
                  cmBiasSelLo};
      pinS2_q <= pinS1_q;
    end
  end

  wire pdnS = pinS2_q[PIN_PDN];
  wire sleepS = pinS2_q[PIN_SLPN];
  wire fmtS = pinS2_q[PIN_FMT];
  wire [1:0] biasS = {pinS2_q[PIN_BHI], pinS2_q[PIN_BLO]};

  // Power state machine
  apoc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic pdOn_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_OFF: begin
        if (pdnS) begin
          state_d = ST_WAKE;
          cnt_d = PD_LOAD;
        end
      end
      ST_WAKE: begin
        if (!sleepS) begin
          state_d = ST_SLEEP;
        end else if (cnt_q == CNT_ZERO) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 1'h1;
        end
      end
      ST_RUN: begin
        if (!sleepS) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (sleepS) begin
          state_d = ST_WAKE;
          cnt_d = SLP_LOAD;
        end
      end
    endcase
    if (!pdnS) begin
      state_d = ST_OFF;
      cnt_d = CNT_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstN_q) begin
      state_q <= ST_OFF;
      cnt_q <= CNT_ZERO;
      pdOn_q <= 1'h1;
      converterActive <= 1'h0;
      cmBiasEn <= BIAS_NONE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pdOn_q <= (state_d == ST_OFF);
      converterActive <= (state_d == ST_RUN);
      cmBiasEn <= pdnS ? apoc_bias_decode(biasS) : BIAS_NONE;
    end
  end

  // Sample entry: format, then clip code on range overflow
  wire run = (state_q == ST_RUN);
  wire adv;
  wire take = coreValid && coreReady && run;
  wire outRange = coreOver || coreUnder;
  wire [DATA_W-1:0] fmtCode = apoc_format(coreSample, fmtS);
  wire [DATA_W-1:0] entryCode = coreOver ? CODE_ONES :
                                coreUnder ? CODE_ZEROS : fmtCode;
  wire [WORD_W-1:0] entryWord = {outRange, entryCode};

  // Fixed latency pipeline, stalled by the buffer
  logic stageV_q [LAT_CYC];
  logic [WORD_W-1:0] stageW_q [LAT_CYC];

  genvar k;
  generate
    for (k = 0; k < LAT_CYC; k++) begin : g_stage
      wire prevV = (k == 0) ? take : stageV_q[(k == 0) ? 0 : k-1];
      wire [WORD_W-1:0] prevW = (k == 0) ? entryWord :
                                stageW_q[(k == 0) ? 0 : k-1];
      always_ff @(posedge sys_clk) begin
        if (!rstN_q || !run) begin
          stageV_q[k] <= 1'h0;
          stageW_q[k] <= '0;
        end else if (adv) begin
          stageV_q[k] <= prevV;
          stageW_q[k] <= prevW;
        end
      end
    end
  endgenerate

  // Buffer between pipeline and clock crossing
  logic bufOutValid;
  logic [WORD_W-1:0] bufOutData;
  logic busy_q;

  apoc_buf2 #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(sys_clk),
    .rstN(rstN_q),
    .inValid(stageV_q[LAT_CYC-1]),
    .inData(stageW_q[LAT_CYC-1]),
    .inReady(coreReady),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outReady(!busy_q)
  );
  assign adv = coreReady;

  // Word handshake towards the link clock
  logic [WORD_W-1:0] hold_q;
  logic req_q, ackS1_q, ackS2_q, ack_q;
  wire handTake = bufOutValid && !busy_q;

  always_ff @(posedge sys_clk) begin
    if (!rstN_q) begin
      hold_q <= '0;
      req_q <= 1'h0;
      busy_q <= 1'h0;
      ackS1_q <= 1'h0;
      ackS2_q <= 1'h0;
    end else begin
      ackS1_q <= ack_q;
      ackS2_q <= ackS1_q;
      if (handTake) begin
        hold_q <= bufOutData;
        req_q <= !req_q;
        busy_q <= 1'h1;
      end else if (busy_q && (ackS2_q == req_q)) begin
        busy_q <= 1'h0;
      end
    end
  end

  // Link clock domain
  logic lrS1_q, linkRstN_q, reqS1_q, reqS2_q;
  logic [LCTL_W-1:0] ctlS1_q, ctlS2_q;

  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      lrS1_q <= 1'h0;
      linkRstN_q <= 1'h0;
    end else begin
      lrS1_q <= 1'h1;
      linkRstN_q <= lrS1_q;
    end
  end

  wire linkPd = ctlS2_q[LCTL_PD];
  wire newWord = (reqS2_q != ack_q);
  wire fallEdge = fwdDataClk || linkPd;

  always_ff @(posedge linkClk) begin
    if (!linkRstN_q) begin
      reqS1_q <= 1'h0;
      reqS2_q <= 1'h0;
      ctlS1_q <= LCTL_RST;
      ctlS2_q <= LCTL_RST;
      ack_q <= 1'h0;
      fwdDataClk <= 1'h0;
      fwdClkOe <= 1'h0;
      dataOe <= 1'h0;
      rangeOe <= 1'h0;
      dataOut <= '0;
      rangeExceededFlag <= 1'h0;
    end else begin
      reqS1_q <= req_q;
      reqS2_q <= reqS1_q;
      ctlS1_q <= {outEnableN, fwdClkEnableN, pdOn_q};
      ctlS2_q <= ctlS1_q;
      fwdDataClk <= linkPd ? 1'h0 : !fwdDataClk;
      fwdClkOe <= !ctlS2_q[LCTL_FWDN];
      dataOe <= !ctlS2_q[LCTL_OEN];
      rangeOe <= !ctlS2_q[LCTL_OEN];
      if (newWord && fallEdge) begin
        ack_q <= reqS2_q;
      end
      if (linkPd) begin
        dataOut <= '0;
        rangeExceededFlag <= 1'h0;
      end else if (newWord && fwdDataClk) begin
        dataOut <= hold_q[DATA_W-1:0];
        rangeExceededFlag <= hold_q[FLAG_BIT];
      end
    end
  end

  // Checks on the sample clock
  logic [3:0] advRun_q;
  always_ff @(posedge sys_clk) begin
    if (!rstN_q || !run || !adv) begin
      advRun_q <= 4'h0;
    end else if (advRun_q != RUN_MAX) begin
      advRun_q <= advRun_q + 4'h1;
    end
  end

  a_pipe_latency: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (advRun_q >= 4'(LAT_CYC)) |-> (stageV_q[LAT_CYC-1] == $past(take, 12)))
    else $error("pipeline latency wrong");
  a_format_twos: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (take && adv && !outRange && fmtS) |=>
    (stageW_q[0][MSB_BIT] == !$past(coreSample[MSB_BIT])))
    else $error("two's complement msb wrong");
  a_over_clip: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (take && adv && coreOver) |=> (stageW_q[0] == {1'h1, CODE_ONES}))
    else $error("over range code not forced");
  a_under_clip: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (take && adv && coreUnder && !coreOver) |=>
    (stageW_q[0] == {1'h1, CODE_ZEROS}))
    else $error("under range code not forced");
  a_pd_state: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    !pdnS |=> (state_q == ST_OFF) ##1 !converterActive)
    else $error("power down not entered");
  a_sleep_enter: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (pdnS && !sleepS && run) |=> (state_q == ST_SLEEP))
    else $error("sleep not entered");
  a_sleep_wake: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (state_q == ST_SLEEP && sleepS && pdnS) |->
    ##[1:SLP_WAIT] (run || !sleepS || !pdnS))
    else $error("sleep wake too slow");
  a_pd_wake: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (state_q == ST_OFF && pdnS) |->
    ##[1:PD_WAIT] (run || !sleepS || !pdnS))
    else $error("power down wake too slow");
  a_bias_off: assert property (@(posedge sys_clk) disable iff (!rstN_q)
    (!pdnS || biasS == BIAS_OFF) |=> (cmBiasEn == BIAS_NONE))
    else $error("bias not off");

  // Checks on the link clock
  a_link_pd_zero: assert property (@(posedge linkClk)
    disable iff (!linkRstN_q)
    linkPd |=> (dataOut == '0 && !rangeExceededFlag && !fwdDataClk))
    else $error("outputs not zero in power down");
  a_fwd_oe: assert property (@(posedge linkClk) disable iff (!linkRstN_q)
    ctlS2_q[LCTL_FWDN] |=> !fwdClkOe)
    else $error("forwarded clock driven while disabled");
  a_data_oe: assert property (@(posedge linkClk) disable iff (!linkRstN_q)
    ctlS2_q[LCTL_OEN] |=> (!dataOe && !rangeOe))
    else $error("data driven while disabled");
  a_fwd_toggle: assert property (@(posedge linkClk)
    disable iff (!linkRstN_q)
    !linkPd |=> (fwdDataClk != $past(fwdDataClk)))
    else $error("forwarded clock stuck");

  c_over_sample: cover property (@(posedge sys_clk) disable iff (!rstN_q)
    take && coreOver);
  c_reach_run: cover property (@(posedge sys_clk) disable iff (!rstN_q)
    $rose(converterActive));
  c_buf_full: cover property (@(posedge sys_clk) disable iff (!rstN_q)
    run && !coreReady);
  c_word_out: cover property (@(posedge linkClk) disable iff (!linkRstN_q)
    newWord && fwdDataClk && !linkPd);

endmodule : apoc_ctrl
`default_nettype wire

/* verification/apoc_capture_model.sv */
/*
  Capture logic model on the far side of the parallel output port.
  Assumes data is stable at each rising forwarded clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module apoc_capture_model import apoc_pkg::*; (
  // Output pins of the block
  input wire logic fwdDataClk,
  input wire logic fwdClkOe,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOe,
  input wire logic rangeExceededFlag,
  input wire logic rangeOe,
  // Captured words
  output logic [DATA_W-1:0] capWord,
  output logic [11:0] capWord12,
  output logic capMsbSmall,
  output logic capFlag
);
  logic capClk;
  logic [DATA_W-1:0] pinWord;
  initial begin
    capWord = 13'h0000;
    capFlag = 1'h0;
  end
  // Floating clock pin gives no edges
  assign capClk = fwdClkOe & fwdDataClk;
  // Floating data pins read as the inverse of the last word
  assign pinWord = dataOe ? dataOut : ~capWord;
  // Capture on rising forwarded clock, pin 0 as LSB, pin 12 as MSB
  always @(posedge capClk) begin
    capWord <= pinWord;
    capFlag <= rangeOe ? rangeExceededFlag : ~capFlag;
  end
  // 12-bit use drops the lowest pin
  assign capWord12 = capWord[12:1];
  // Smaller range takes pin 11 as MSB
  assign capMsbSmall = capWord[11];
endmodule : apoc_capture_model
`default_nettype wire

/* verification/apoc_ctrl_tb_top.sv */
/*
  Self-checking testbench of the converter control block.
  Assumes the capture model sits on the parallel output pins.
*/
`timescale 1ns/1ns
`default_nettype none
module apoc_ctrl_tb_top import apoc_pkg::*;;
  logic sys_clk = 1'b0, nrst = 1'b1, linkClk = 1'b0;
  logic powerDownN = 1'b0, sleepN = 1'b1, numberFormatSel = 1'b0;
  logic cmBiasSelHi = 1'b0, cmBiasSelLo = 1'b0;
  logic fwdClkEnableN = 1'b0, outEnableN = 1'b0;
  logic [DATA_W-1:0] coreSample = 13'h0000;
  logic coreOver = 1'b0, coreUnder = 1'b0, coreValid = 1'b0;
  logic coreReady, dataOe, rangeExceededFlag, rangeOe, fwdDataClk;
  logic fwdClkOe, converterActive, capFlag, capMsbSmall, sawStall = 1'b0;
  logic [DATA_W-1:0] dataOut, capWord, prevCap = 13'h0000;
  logic prevFlag = 1'h0;
  logic [11:0] capWord12;
  logic [3:0] cmBiasEn;
  int mismatches = 0, checks = 0, n;

  always #5 sys_clk = ~sys_clk;
  initial begin
    #33;
    forever #80 linkClk = ~linkClk;
  end

  apoc_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .linkClk(linkClk),
    .powerDownN(powerDownN), .sleepN(sleepN),
    .numberFormatSel(numberFormatSel), .cmBiasSelHi(cmBiasSelHi),
    .cmBiasSelLo(cmBiasSelLo), .fwdClkEnableN(fwdClkEnableN),
    .outEnableN(outEnableN), .coreSample(coreSample),
    .coreOver(coreOver), .coreUnder(coreUnder), .coreValid(coreValid),
    .coreReady(coreReady), .dataOut(dataOut), .dataOe(dataOe),
    .rangeExceededFlag(rangeExceededFlag), .rangeOe(rangeOe),
    .fwdDataClk(fwdDataClk), .fwdClkOe(fwdClkOe), .cmBiasEn(cmBiasEn),
    .converterActive(converterActive));

  apoc_capture_model cap (.fwdDataClk(fwdDataClk), .fwdClkOe(fwdClkOe),
    .dataOut(dataOut), .dataOe(dataOe),
    .rangeExceededFlag(rangeExceededFlag), .rangeOe(rangeOe),
    .capWord(capWord), .capWord12(capWord12), .capMsbSmall(capMsbSmall),
    .capFlag(capFlag));

  // Buffer refusing while a sample is offered
  always @(posedge sys_clk) begin
    if (coreValid && coreReady === 1'b0) begin
      sawStall <= 1'b1;
    end
  end

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Offer one sample, held until taken; valid stays up
  task automatic send_word(input logic [12:0] c, input logic ov, un);
    int k;
    @(negedge sys_clk);
    coreSample = c;
    coreOver = ov;
    coreUnder = un;
    coreValid = 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (coreReady !== 1'b1 && k < 2000);
  endtask : send_word

  task automatic idle();
    @(negedge sys_clk);
    coreValid = 1'b0;
  endtask : idle

  // Wait for the next captured word and compare it
  task automatic next_word(input logic [12:0] c, input logic f);
    int k;
    k = 0;
    while ({capFlag, capWord} === {prevFlag, prevCap} && k < 800) begin
      @(posedge sys_clk);
      k++;
    end
    prevCap = capWord;
    prevFlag = capFlag;
    check({capFlag, capWord}, {f, c});
  endtask : next_word

  task automatic wait_active(input int lim);
    n = 0;
    while (converterActive !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_active

  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  initial begin
    #1;
    nrst = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (5) @(negedge sys_clk);
    check({converterActive, cmBiasEn, dataOut[8:0]}, 14'h0000);
    powerDownN = 1'b1;
    wait_active(900);
    check(converterActive, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      {cmBiasSelHi, cmBiasSelLo} = i[1:0];
      repeat (5) @(negedge sys_clk);
      check(cmBiasEn, (i == 0) ? 4'h0 : 4'h1 << (i - 1));
    end
    send_word(13'h0123, 1'b0, 1'b0);
    idle();
    next_word(13'h0123, 1'b0);
    check(capWord12, 12'h091);
    @(negedge sys_clk);
    numberFormatSel = 1'b1;
    repeat (20) @(negedge sys_clk);
    send_word(13'h0123, 1'b0, 1'b0);
    idle();
    next_word(13'h1123, 1'b0);
    send_word(13'h0456, 1'b1, 1'b0);
    idle();
    next_word(13'h1FFF, 1'b1);
    check(capMsbSmall, 1'b1);
    send_word(13'h0456, 1'b0, 1'b1);
    idle();
    next_word(13'h0000, 1'b1);
    @(negedge sys_clk);
    numberFormatSel = 1'b0;
    repeat (20) @(negedge sys_clk);
    fork
      begin
        for (int i = 0; i < 20; i++) begin
          send_word(13'h0100 + i[12:0], 1'b0, 1'b0);
        end
        idle();
      end
      for (int j = 0; j < 20; j++) begin
        next_word(13'h0100 + j[12:0], 1'b0);
      end
    join
    check(sawStall, 1'b1);
    @(negedge sys_clk);
    outEnableN = 1'b1;
    fwdClkEnableN = 1'b1;
    repeat (6) @(negedge linkClk);
    check({dataOe, rangeOe, fwdClkOe}, 3'h0);
    @(negedge sys_clk);
    outEnableN = 1'b0;
    fwdClkEnableN = 1'b0;
    repeat (6) @(negedge linkClk);
    check({dataOe, rangeOe, fwdClkOe}, 3'h7);
    @(negedge sys_clk);
    sleepN = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(converterActive, 1'b0);
    sleepN = 1'b1;
    wait_active(20);
    check(converterActive, 1'b1);
    @(negedge sys_clk);
    powerDownN = 1'b0;
    repeat (8) @(posedge linkClk);
    @(negedge sys_clk);
    check({converterActive, cmBiasEn, fwdDataClk}, 14'h0000);
    check({rangeExceededFlag, dataOut}, 14'h0000);
    finish_test();
  end
endmodule : apoc_ctrl_tb_top
`default_nettype wire
